// ### hdl/serial_unit.sv
// Serial unit: APB registers, rate generator, UART and SPI byte engines
//
// Function
// - Bit rate is clock times (256+mantissa) times 2^exponent over 2^28.
// - One rate generator paces UART bits and the SPI master clock.
// - UART top rate is clock/16 at exponent 16, mantissa 0.
// - SPI master with reception tops out at clock/8, exponent 17.
// - SPI master without reception may reach clock/2 at exponent 19.
// - An external SPI slave clock must stay at or below clock/8.
// - At 26 MHz, 131/8 gives 9600 and 34/12 gives 115200.
// - At 24 MHz, 163/8 gives 9600 and 59/12 gives 115200.
// - Writing flush stops the transfer and clears all data buffers.
// - Receive and transmit done flags raise a request only when enabled.
// - Two DMA triggers pulse on the same done events as the flags.
// - The data buffer register serves as a DMA source or destination.
// - Five unit registers: status, line control, generic, data, mantissa; this unit also maps interrupt flag and enable registers.
// - Status bit 7 picks SPI or UART, bit 5 master or slave.
// - Status bit 6 enables the UART receiver; read/write, resets low.
// - Status bit 4 reports a framing fault; resets low.
// - Line control bit 7 is a one-shot flush that always reads zero.
// - Busy status reads one while transmitting or receiving.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module serial_unit
   import serial_pkg::*;
(
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Serial pins
   input  wire serial_pkg::pins_in_t  pin_i,
   output serial_pkg::pins_out_t      pin_o,
   // Requests to the interrupt and DMA controllers
   output logic                       rx_irq,
   output logic                       tx_irq,
   output logic                       dma_rx_trig,
   output logic                       dma_tx_trig
);
   import serial_pkg::*;

   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_RUN = 2'b10} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_DATA = 3'b010, RX_STOP = 3'b100} rx_state_t;

   tx_state_t   tx_st;
   rx_state_t   rx_st;
   pins_in_t    pin_s1;
   pins_in_t    pin_s2;
   logic        mode;
   logic        receiver_on;
   logic        slave;
   logic        framing_fault;
   logic        parity_fault;
   logic        rx_byte;
   logic        tx_byte;
   logic [6:0]  uart_line_control;
   logic [7:0]  generic_serial_control;
   logic [7:0]  rate_mantissa_reg;
   logic [7:0]  rx_data;
   logic [7:0]  tx_data;
   logic        rx_done_flag;
   logic        tx_done_flag;
   logic        rx_done_irq_en;
   logic        tx_done_irq_en;
   logic [9:0]  sh;
   logic [3:0]  cnt;
   logic        sck_q;
   logic        cap;
   logic        sck_prev;
   logic        ssn_prev;
   logic [7:0]  rsh;
   logic [3:0]  rcnt;
   logic        bit_tick;
   logic        half_tick;
   logic [7:0]  rd_mux;
   logic        rate_restart;

   // ----------------------------------------------------------------
   // Pin synchronisers; only the second stage is read
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1 <= PINS_IDLE;
         pin_s2 <= PINS_IDLE;
      end
      else
      begin
         pin_s1 <= pin_i;
         pin_s2 <= pin_s1;
      end
   end

   // ----------------------------------------------------------------
   // APB decode; zero wait states, unmapped addresses answer an error
   // ----------------------------------------------------------------
   wire setup    = psel & ~penable;
   wire access   = psel & penable;
   wire wr       = access & pwrite;
   wire rd       = access & ~pwrite;
   wire hit_csr  = paddr == OFS_CSR;
   wire hit_ucr  = paddr == OFS_UCR;
   wire hit_gcr  = paddr == OFS_GCR;
   wire hit_dbuf = paddr == OFS_DBUF;
   wire hit_baud = paddr == OFS_BAUD;
   wire hit_iflg = paddr == OFS_IFLG;
   wire hit_ien  = paddr == OFS_IEN;
   wire mapped   = hit_csr | hit_ucr | hit_gcr | hit_dbuf | hit_baud | hit_iflg | hit_ien;
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // Write and read strobes and one-shot controls
   wire flush    = wr & hit_ucr & pwdata[UCR_FLUSH];
   wire dbuf_wr  = wr & hit_dbuf;
   wire dbuf_rd  = rd & hit_dbuf;
   wire csr_wr   = wr & hit_csr;
   wire csr_rd   = rd & hit_csr;
   wire clr_rxf  = wr & hit_iflg & pwdata[FLG_RX];
   wire clr_txf  = wr & hit_iflg & pwdata[FLG_TX];

   // ----------------------------------------------------------------
   // Rate generator shared by UART and SPI master
   // ----------------------------------------------------------------
   rate_gen u_rate (
      .pclk      (pclk),
      .presetn   (presetn),
      .restart   (rate_restart),
      .baud_m    (rate_mantissa_reg),
      .baud_e    (generic_serial_control[4:0]),
      .bit_tick  (bit_tick),
      .half_tick (half_tick)
   );

   // ----------------------------------------------------------------
   // Engine conditions
   // ----------------------------------------------------------------
   wire cpol      = generic_serial_control[GCR_CPOL];
   wire spi_mst   = ~mode & ~slave;
   wire spi_slv   = ~mode & slave;
   wire tx_idle   = tx_st == TX_IDLE;
   wire tx_start  = dbuf_wr & tx_idle & ~spi_slv;
   // Restart on start too: the first bit or SPI half period is full, so the
   // synchronised far-side data is settled; a receive in flight loses alignment
   assign rate_restart = flush | tx_start;
   wire ssn_act   = ~pin_s2.ssn_n;
   wire ssn_fall  = ssn_act & ~ssn_prev;
   // Slave clock edges come from the synchronised pin, so it must run slow
   wire sck_s     = pin_s2.sck ^ cpol;
   wire lead      = spi_mst ? (half_tick & ~tx_idle & ~sck_q)
                            : (spi_slv & ssn_act & sck_s & ~sck_prev);
   wire trail     = spi_mst ? (half_tick & ~tx_idle & sck_q)
                            : (spi_slv & ssn_act & ~sck_s & sck_prev);
   wire spi_done  = ~mode & trail & (cnt == SPI_LAST);
   wire utx_step  = mode & ~tx_idle & bit_tick;
   wire utx_done  = utx_step & (cnt == UART_LAST);
   wire urx_done  = mode & (rx_st == RX_STOP) & bit_tick;
   wire stop_bad  = urx_done & ~pin_s2.rxd;
   wire rx_ev     = urx_done | spi_done;
   wire tx_ev     = tx_start | (spi_slv & ssn_fall);
   wire busy      = ~tx_idle | (rx_st != RX_IDLE) | (spi_slv & ssn_act);

   // ----------------------------------------------------------------
   // Byte engine shared by UART transmit and SPI shifting
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_st <= TX_IDLE;
         sh    <= '1;
         cnt   <= '0;
         sck_q <= 1'b0;
         cap   <= 1'b0;
      end
      else if (flush)
      begin
         tx_st <= TX_IDLE;
         sh    <= '1;
         cnt   <= '0;
         sck_q <= 1'b0;
      end
      else if (tx_start)
      begin
         tx_st <= TX_RUN;
         sh    <= mode ? {1'b1, pwdata[7:0], 1'b0} : {2'b11, pwdata[7:0]};
         cnt   <= '0;
      end
      else if (utx_step)
      begin
         // UART frame leaves lowest bit first, one bit per rate enable
         sh    <= {1'b1, sh[9:1]};
         cnt   <= cnt + 4'h1;
         tx_st <= utx_done ? TX_IDLE : TX_RUN;
      end
      else
      begin
         if (spi_mst && half_tick && !tx_idle)
            sck_q <= ~sck_q;
         if (lead)
            cap <= spi_mst ? pin_s2.miso : pin_s2.mosi;
         if (trail)
         begin
            sh  <= spi_done && spi_slv ? {2'b11, tx_data} : {sh[9:8], sh[6:0], cap};
            cnt <= spi_done ? 4'h0 : cnt + 4'h1;
         end
         if (spi_done && spi_mst)
            tx_st <= TX_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // UART receiver; samples once per bit enable, no oversampling
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_st <= RX_IDLE;
         rsh   <= RST_BYTE;
         rcnt  <= '0;
      end
      else if (flush || !receiver_on || !mode)
         rx_st <= RX_IDLE;
      else if (bit_tick)
      begin
         case (rx_st)
            RX_IDLE:
               if (!pin_s2.rxd)
               begin
                  rx_st <= RX_DATA;
                  rcnt  <= '0;
               end
            RX_DATA:
            begin
               rsh   <= {pin_s2.rxd, rsh[7:1]};
               rcnt  <= rcnt + 4'h1;
               if (rcnt == RX_LAST)
                  rx_st <= RX_STOP;
            end
            RX_STOP: rx_st <= RX_IDLE;
            default: rx_st <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Software registers; hardware sets win over clears in one cycle, except that flush clears rx_byte and tx_byte
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode                   <= 1'b0;
         receiver_on            <= 1'b0;
         slave                  <= 1'b0;
         uart_line_control      <= '0;
         generic_serial_control <= RST_BYTE;
         rate_mantissa_reg      <= RST_BYTE;
         tx_data                <= RST_BYTE;
         rx_done_irq_en         <= 1'b0;
         tx_done_irq_en         <= 1'b0;
      end
      else
      begin
         if (csr_wr)
         begin
            mode        <= pwdata[CSR_MODE];
            receiver_on <= pwdata[CSR_RXON];
            slave       <= pwdata[CSR_SLAVE];
         end
         if (wr && hit_ucr)
            uart_line_control <= pwdata[6:0];
         if (wr && hit_gcr)
            generic_serial_control <= pwdata[7:0];
         if (wr && hit_baud)
            rate_mantissa_reg <= pwdata[7:0];
         if (flush)
            tx_data <= RST_BYTE;
         else if (dbuf_wr)
            tx_data <= pwdata[7:0];
         if (wr && hit_ien)
         begin
            rx_done_irq_en <= pwdata[FLG_RX];
            tx_done_irq_en <= pwdata[FLG_TX];
         end
      end
   end

   // Status bits and done flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         framing_fault <= 1'b0;
         parity_fault  <= 1'b0;
         rx_byte       <= 1'b0;
         tx_byte       <= 1'b0;
         rx_data       <= RST_BYTE;
         rx_done_flag  <= 1'b0;
         tx_done_flag  <= 1'b0;
         dma_rx_trig   <= 1'b0;
         dma_tx_trig   <= 1'b0;
         ssn_prev      <= 1'b0;
         sck_prev      <= 1'b0;
      end
      else
      begin
         framing_fault <= stop_bad | (csr_wr ? pwdata[CSR_FE] : framing_fault & ~csr_rd);
         parity_fault  <= csr_wr ? pwdata[CSR_ERR] : parity_fault & ~csr_rd;
         rx_byte       <= ~flush & (rx_ev | (csr_wr ? pwdata[CSR_RXB] : rx_byte & ~dbuf_rd));
         tx_byte       <= ~flush & (utx_done | (spi_done & spi_mst)
                          | (csr_wr ? pwdata[CSR_TXB] : tx_byte));
         if (flush)
            rx_data <= RST_BYTE;
         else if (rx_ev)
            rx_data <= mode ? rsh : {sh[6:0], cap};
         rx_done_flag  <= rx_ev | (rx_done_flag & ~clr_rxf);
         tx_done_flag  <= tx_ev | (tx_done_flag & ~clr_txf);
         dma_rx_trig   <= rx_ev;
         dma_tx_trig   <= tx_ev;
         ssn_prev      <= ssn_act;
         sck_prev      <= sck_s;
      end
   end

   // ----------------------------------------------------------------
   // Read data, latched in the setup cycle; flush always reads zero
   // ----------------------------------------------------------------
   assign rd_mux =
      hit_csr  ? {mode, receiver_on, slave, framing_fault, parity_fault,
                  rx_byte, tx_byte, busy} :
      hit_ucr  ? {1'b0, uart_line_control} :
      hit_gcr  ? generic_serial_control :
      hit_dbuf ? rx_data :
      hit_baud ? rate_mantissa_reg :
      hit_iflg ? {6'h00, tx_done_flag, rx_done_flag} :
      hit_ien  ? {6'h00, tx_done_irq_en, rx_done_irq_en} : RST_BYTE;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (setup && !pwrite)
         prdata <= {24'h000000, rd_mux};
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rx_irq = rx_done_flag & rx_done_irq_en;
   assign tx_irq = tx_done_flag & tx_done_irq_en;
   assign pin_o  = '{txd:    mode ? (tx_idle | sh[0]) : 1'b1,
                     mosi:   sh[7],
                     miso:   sh[7],
                     sck:    sck_q ^ cpol,
                     sck_oe: spi_mst};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_flush_to_idle: assert property (@(posedge pclk) disable iff (!presetn)
      flush |=> tx_st == TX_IDLE && rx_st == RX_IDLE && !rx_byte && rx_data == RST_BYTE)
      else $error("flush left the unit active or data kept");

   a_flush_reads_low: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_ucr) |=> !prdata[UCR_FLUSH])
      else $error("flush bit read back as one");

   a_busy_shows: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_csr && tx_st == TX_RUN) |=> prdata[0])
      else $error("busy bit low during a transfer");

   a_rx_request: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_ev && rx_done_irq_en && !(wr && hit_ien)) |=> rx_irq && rx_done_flag)
      else $error("enabled receive event raised no request");

   a_tx_masked: assert property (@(posedge pclk) disable iff (!presetn)
      !tx_done_irq_en |-> !tx_irq)
      else $error("transmit request without enable");

   a_dma_with_flag: assert property (@(posedge pclk) disable iff (!presetn)
      tx_ev |=> dma_tx_trig && tx_done_flag ##1 !dma_tx_trig || $past(tx_ev))
      else $error("transmit trigger not paired with its flag");

   a_framing_cause: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(framing_fault) |-> $past(stop_bad) || $past(csr_wr))
      else $error("framing fault set without a bad stop bit");

   a_uart_start_bit: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_start && mode) |=> !pin_o.txd ##1 !pin_o.txd)
      else $error("UART frame did not open with a start bit");

   c_uart_tx: cover property (@(posedge pclk) disable iff (!presetn) utx_done);
   c_spi_byte: cover property (@(posedge pclk) disable iff (!presetn) spi_done && spi_mst);
   c_framing: cover property (@(posedge pclk) disable iff (!presetn) stop_bad);
   c_rate_9600: cover property (@(posedge pclk) disable iff (!presetn)
      bit_tick && rate_mantissa_reg == M_9600_26M
      && generic_serial_control[4:0] == E_9600_26M);

endmodule

// ### hdl/serial_pkg.sv
// Register map, field positions, counts and carrier types of the serial unit
package serial_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CSR  = 8'h00;
   localparam logic [7:0] OFS_UCR  = 8'h04;
   localparam logic [7:0] OFS_GCR  = 8'h08;
   localparam logic [7:0] OFS_DBUF = 8'h0c;
   localparam logic [7:0] OFS_BAUD = 8'h10;
   localparam logic [7:0] OFS_IFLG = 8'h14;
   localparam logic [7:0] OFS_IEN  = 8'h18;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CSR_MODE  = 7;
   localparam int CSR_RXON  = 6;
   localparam int CSR_SLAVE = 5;
   localparam int CSR_FE    = 4;
   localparam int CSR_ERR   = 3;
   localparam int CSR_RXB   = 2;
   localparam int CSR_TXB   = 1;
   localparam int UCR_FLUSH = 7;
   localparam int GCR_CPOL  = 7;
   localparam int GCR_CLOCK_PHASE_SELECT  = 6;
   localparam int FLG_RX    = 0;
   localparam int FLG_TX    = 1;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [3:0] SPI_LAST    = 4'h7;
   localparam logic [3:0] UART_LAST   = 4'h9;
   localparam logic [3:0] RX_LAST     = 4'h7;
   localparam int         ACC_W       = 28;
   localparam int         INC_W       = 40;
   localparam int         UART_MAX_DIV = 16;
   localparam int         SPI_MAX_DIV  = 8;

   // ----------------------------------------------------------------
   // Rate settings named by the rate table and the top speeds
   // ----------------------------------------------------------------
   localparam logic [7:0] M_9600_26M   = 8'd131;
   localparam logic [4:0] E_9600_26M   = 5'd8;
   localparam logic [7:0] M_115K_26M   = 8'd34;
   localparam logic [4:0] E_115K_26M   = 5'd12;
   localparam logic [7:0] M_9600_24M   = 8'd163;
   localparam logic [7:0] M_115K_24M   = 8'd59;
   localparam logic [4:0] E_UART_MAX   = 5'd16;
   localparam logic [4:0] E_SPI_MAX    = 5'd17;
   localparam logic [4:0] E_SPI_TX_MAX = 5'd19;

   // ----------------------------------------------------------------
   // Pin carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rxd;
      logic miso;
      logic mosi;
      logic sck;
      logic ssn_n;
   } pins_in_t;

   typedef struct packed {
      logic txd;
      logic mosi;
      logic miso;
      logic sck;
      logic sck_oe;
   } pins_out_t;

   localparam pins_in_t PINS_IDLE = '{rxd: 1'b1, miso: 1'b0, mosi: 1'b0, sck: 1'b0,
                                      ssn_n: 1'b1};

endpackage

// ### hdl/rate_gen.sv
// Fractional rate generator: bit and half-bit enables from mantissa and exponent
`timescale 1ns/1ps
module rate_gen
   import serial_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       restart,
   input  wire logic [7:0] baud_m,
   input  wire logic [4:0] baud_e,
   // Enables
   output logic            bit_tick,
   output logic            half_tick
);

   logic [ACC_W-1:0] acc;
   logic [INC_W-1:0] inc;
   logic [INC_W-1:0] sum;
   logic             next_bit;
   logic             next_half;
   logic [12:0]      cfg_q;
   logic             cfg_moved;
   logic             rate_upset;

   // Step per clock is (256+M)<<E against a 2^28 wrap
   assign inc       = {31'h0, 1'b1, baud_m} << baud_e;
   assign sum       = {12'h0, acc} + inc;
   assign next_bit  = |sum[INC_W-1:ACC_W];
   // Crossing a multiple of 2^27 marks each half period of the serial clock
   assign next_half = sum[INC_W-1:ACC_W-1] != {12'h0, acc[ACC_W-1]};
   // A settings change or a restart breaks one period, so the period checks skip it
   assign cfg_moved  = {baud_m, baud_e} != cfg_q;
   assign rate_upset = restart | cfg_moved;

   // Settings copy, used by the period checks only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_q <= '0;
      else
         cfg_q <= {baud_m, baud_e};
   end

   // ----------------------------------------------------------------
   // Accumulator; a flush restarts it so the next bit is a full period
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc       <= '0;
         bit_tick  <= 1'b0;
         half_tick <= 1'b0;
      end
      else if (restart)
      begin
         acc       <= '0;
         bit_tick  <= 1'b0;
         half_tick <= 1'b0;
      end
      else
      begin
         acc       <= sum[ACC_W-1:0];
         bit_tick  <= next_bit;
         half_tick <= next_half;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_uart_max_rate: assert property (@(posedge pclk)
      disable iff (!presetn || rate_upset)
      (bit_tick && baud_m == 8'h00 && baud_e == E_UART_MAX && !rate_upset)
      |-> ##16 bit_tick)
      else $error("top UART rate is not one sixteenth of the clock");

   a_spi_max_rate: assert property (@(posedge pclk)
      disable iff (!presetn || rate_upset)
      (bit_tick && baud_m == 8'h00 && baud_e == E_SPI_MAX && !rate_upset)
      |-> ##8 bit_tick)
      else $error("top SPI rate is not one eighth of the clock");

   a_spi_tx_rate: assert property (@(posedge pclk) disable iff (!presetn)
      (baud_m == 8'h00 && baud_e == E_SPI_TX_MAX && !restart) |=> half_tick)
      else $error("top SPI transmit rate is not half the clock");

   a_restart_full: assert property (@(posedge pclk) disable iff (!presetn)
      (restart && baud_e <= E_SPI_TX_MAX) |=> !bit_tick ##1 !bit_tick)
      else $error("bit enable came early after restart");

endmodule

// ### tb/serial_peer.sv
// Far-side peer model: UART line echo and inverting SPI slave
`timescale 1ns/1ps
module serial_peer
   import serial_pkg::*;
(
   // Bench control: hold the line low to force bad stop bits
   input  wire logic                  line_break,
   // Pins seen from the far side
   input  wire serial_pkg::pins_out_t to_peer,
   output serial_pkg::pins_in_t       from_peer
);
   // Echo txd, answer inverted mosi; sck and select idle, so never above clock/8
   assign from_peer = '{rxd: to_peer.txd & ~line_break, miso: ~to_peer.mosi, mosi: 1'b0,
                        sck: 1'b0, ssn_n: 1'b1};
endmodule

// ### tb/serial_unit_test.sv
// Self-checking bench for the serial unit over APB
`timescale 1ns/1ps
module serial_unit_test;
   import serial_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, rx_irq, tx_irq, dma_rx_trig, dma_tx_trig, ps;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   pins_in_t    pin_i;
   pins_out_t   pin_o;
   int          errors = 0, check_count = 0, cycles = 0, n_rx = 0, n_tx = 0;
   logic        line_break = 1'b0;
   always #50 pclk = ~pclk;
   serial_unit DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pin_i, .pin_o, .rx_irq, .tx_irq, .dma_rx_trig, .dma_tx_trig);
   serial_peer peer (.line_break(line_break), .to_peer(pin_o), .from_peer(pin_i));
   // Trigger counts and hang guard; a stuck wait ends in the report
   always @(posedge pclk)
   begin
      n_rx <= n_rx + dma_rx_trig;
      n_tx <= n_tx + dma_tx_trig;
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      ps = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_flag(input int b);
      do apb(1'b0, OFS_IFLG, 32'h0); while (rdv[b] !== 1'b1);
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CSR, 32'h0);
      check(rdv, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      check({rdv[30:0], ps}, 32'h1);
      $display("reset test done");
      // UART byte echoed back by the peer at the top rate
      apb(1'b1, OFS_BAUD, 32'h0);
      apb(1'b1, OFS_GCR, {27'h0, E_UART_MAX});
      apb(1'b1, OFS_IEN, 32'h3);
      apb(1'b1, OFS_CSR, 32'hc0);
      apb(1'b1, OFS_DBUF, 32'ha5);
      apb(1'b0, OFS_CSR, 32'h0);
      check({rdv[0], tx_irq}, 32'h3);
      wait_flag(FLG_RX);
      check({31'h0, rx_irq}, 32'h1);
      apb(1'b0, OFS_DBUF, 32'h0);
      check(rdv, 32'ha5);
      apb(1'b1, OFS_IEN, 32'h0);
      @(posedge pclk); // Enable write lands at the access edge; look one edge later
      check({rx_irq, tx_irq}, 32'h0);
      apb(1'b1, OFS_IFLG, 32'h3);
      $display("uart test done");
      // Flush in mid-transmit, then wait more than one bit
      apb(1'b1, OFS_DBUF, 32'h5a);
      apb(1'b1, OFS_UCR, 32'h85);
      repeat (20) @(posedge pclk);
      apb(1'b0, OFS_UCR, 32'h0);
      check(rdv, 32'h05);
      apb(1'b0, OFS_CSR, 32'h0);
      check(rdv & 32'h7, 32'h0);
      $display("flush test done");
      // SPI master at clock/8; peer returns the inverted byte
      apb(1'b1, OFS_CSR, 32'h0);
      apb(1'b1, OFS_GCR, {27'h0, E_SPI_MAX});
      apb(1'b1, OFS_DBUF, 32'h3c);
      wait_flag(FLG_RX);
      apb(1'b0, OFS_DBUF, 32'h0);
      check(rdv, 32'hc3);
      check({32'(n_rx), 32'(n_tx)} == {32'h2, 32'h3}, 32'h1);
      $display("spi test done");
      // SPI master sending only at clock/2; clock/8 would still be busy
      apb(1'b1, OFS_CSR, 32'h0);
      apb(1'b1, OFS_GCR, {27'h0, E_SPI_TX_MAX});
      apb(1'b1, OFS_DBUF, 32'h96);
      repeat (30) @(posedge pclk);
      apb(1'b0, OFS_CSR, 32'h0);
      check(rdv & 32'h3, 32'h2);
      $display("spi fast test done");
      // Line held low: the frame ends in a bad stop bit
      apb(1'b1, OFS_IFLG, 32'h3);
      apb(1'b1, OFS_GCR, {27'h0, E_UART_MAX});
      apb(1'b1, OFS_CSR, 32'hc0);
      line_break <= 1'b1;
      wait_flag(FLG_RX);
      line_break <= 1'b0;
      apb(1'b0, OFS_CSR, 32'h0);
      check(rdv & 32'h14, 32'h14);
      apb(1'b0, OFS_DBUF, 32'h0);
      check(rdv, 32'h0);
      apb(1'b0, OFS_CSR, 32'h0);
      check(rdv & 32'h14, 32'h0);
      $display("framing test done");
      conclude();
   end
endmodule
